// [rtl/sosc_top.sv]
// How it works
// [RL1] select low: start taking bits, drive serial output with top shift bit
// [RL2] select rising: copy shift register to latches only if count is multiple of 8
// [RL3] select high again: serial output returns to high impedance
// [RL4] host keeps shift clock high while select changes
// [RL5] select high: ignore clock and data, serial output stays high impedance
// [RL6] modulo counter per frame; wrong count discards transfer, latches unchanged
// [RL7] sample serial input on rising clock edge, most significant bit first
// [RL8] top bit out first, next bit after each falling clock edge
// [RL9] each clock shifts one bit in, all move on, last bit out
// [RL10] four rejected transfers switch all outputs off until next valid data
// [RL11] fault output low on any overtemperature flag or supply undervoltage
// [RL12] hot channel alone shuts down, restarts when cooled
// [RL13] high bit switches its channel on, low bit switches it off
// [RL14] disable low clears latches, outputs off until new data written
// [RL15] eight bit register, bit n drives channel n, first bit is bit 7
`timescale 1ns/1ps
`default_nettype none
module sosc_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so_o,
  output logic             so_oe_n,
  // output stage
  input  wire logic        output_disable_n,
  input  wire logic [7:0]  ovt_flags,
  input  wire logic        uv_flag,
  output logic [7:0]       channel_outputs,
  // common fault pin, open drain
  input  wire logic        common_fault_i,
  output logic             common_fault_o,
  output logic             common_fault_oe_n,
  // interrupt
  output logic             irq
);

  // ****************************************
  // input synchronisers
  // ****************************************
  sosc_pkg::sosc_spi_s spi_s1_q, spi_s2_q, spi_d;
  logic [7:0]          ovt_s1_q, ovt_s2_q;
  logic                uv_s1_q, uv_s2_q;
  logic                pin_s1_q, pin_s2_q;
  logic                sclk_s3_q;
  logic                dis_rst_n;
  assign spi_d = {cs_n, sclk, si};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_s1_q  <= 3'h7;
      spi_s2_q  <= 3'h7;
      sclk_s3_q <= 1'b1;
      ovt_s1_q  <= sosc_pkg::SOSC_BYTE_RST;
      ovt_s2_q  <= sosc_pkg::SOSC_BYTE_RST;
      uv_s1_q   <= 1'b0;
      uv_s2_q   <= 1'b0;
      pin_s1_q  <= 1'b1;
      pin_s2_q  <= 1'b1;
    end else begin
      spi_s1_q  <= spi_d;
      spi_s2_q  <= spi_s1_q;
      sclk_s3_q <= spi_s2_q.sclk;
      ovt_s1_q  <= ovt_flags;
      ovt_s2_q  <= ovt_s1_q;
      uv_s1_q   <= uv_flag;
      uv_s2_q   <= uv_s1_q;
      pin_s1_q  <= common_fault_i;
      pin_s2_q  <= pin_s1_q;
    end
  end
  // disable pin clears latches at once
  assign dis_rst_n = arst_n & output_disable_n;

  // ****************************************
  // serial shift engine
  // ****************************************
  sosc_pkg::sosc_state_e state_q, state_d;
  logic [7:0] sreg_q, sreg_d;
  logic [2:0] cnt_q, cnt_d;
  logic       any_q, any_d;
  logic       so_q, so_d;
  logic       so_oe_n_q, so_oe_n_d;
  logic       rise_w, fall_w, valid_w;

  assign rise_w  = spi_s2_q.sclk & ~sclk_s3_q;
  assign fall_w  = ~spi_s2_q.sclk & sclk_s3_q;
  assign valid_w = (cnt_q == sosc_pkg::SOSC_CNT_ZERO) & any_q;
  always_comb begin
    state_d   = state_q;
    sreg_d    = sreg_q;
    cnt_d     = cnt_q;
    any_d     = any_q;
    so_d      = so_q;
    so_oe_n_d = so_oe_n_q;
    case (state_q)
      sosc_pkg::SOSC_IDLE: begin
        if (!spi_s2_q.cs_n) begin
          state_d   = sosc_pkg::SOSC_SHIFT;
          cnt_d     = sosc_pkg::SOSC_CNT_ZERO;
          any_d     = 1'b0;
          so_d      = sreg_q[7]; // RL1
          so_oe_n_d = 1'b0; // RL1
        end else begin
          so_oe_n_d = 1'b1; // RL5
        end
      end
      sosc_pkg::SOSC_SHIFT: begin
        if (spi_s2_q.cs_n) begin
          state_d   = sosc_pkg::SOSC_COMMIT;
          so_oe_n_d = 1'b1; // RL3
        end else if (rise_w) begin
          sreg_d = {sreg_q[6:0], spi_s2_q.si}; // RL7 RL9
          cnt_d  = cnt_q + 3'h1; // RL6
          any_d  = 1'b1;
        end else if (fall_w) begin
          so_d = sreg_q[7]; // RL8 RL9
        end
      end
      sosc_pkg::SOSC_COMMIT: begin
        state_d = sosc_pkg::SOSC_IDLE;
      end
      default: begin
        state_d   = sosc_pkg::SOSC_IDLE;
        so_oe_n_d = 1'b1;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= sosc_pkg::SOSC_IDLE;
      cnt_q     <= sosc_pkg::SOSC_CNT_ZERO;
      any_q     <= 1'b0;
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      any_q     <= any_d;
      so_q      <= so_d;
      so_oe_n_q <= so_oe_n_d;
    end
  end
  always_ff @(posedge sys_clk or negedge dis_rst_n) begin
    if (!dis_rst_n) begin
      sreg_q <= sosc_pkg::SOSC_BYTE_RST; // RL14
    end else begin
      sreg_q <= sreg_d;
    end
  end
  assign so_o    = so_q;
  assign so_oe_n = so_oe_n_q;

  // ****************************************
  // output latches and protection
  // ****************************************
  logic [7:0] latch_q, latch_d;
  logic [7:0] chan_q, chan_d;
  logic [2:0] rej_q, rej_d;
  logic       off_q, off_d;
  logic       commit_w, fault_w;
  logic       fault_oe_n_q, fault_oe_n_d;
  assign commit_w = (state_q == sosc_pkg::SOSC_COMMIT);
  assign fault_w  = (|ovt_s2_q) | uv_s2_q; // RL11
  always_comb begin
    latch_d = latch_q;
    rej_d   = rej_q;
    off_d   = off_q;
    if (commit_w) begin
      if (valid_w) begin
        latch_d = sreg_q; // RL2 RL15
        rej_d   = sosc_pkg::SOSC_CNT_ZERO;
        off_d   = 1'b0; // RL10
      end else if (rej_q != sosc_pkg::SOSC_REJ_LIMIT) begin
        rej_d = rej_q + 3'h1; // RL6
        off_d = (rej_d == sosc_pkg::SOSC_REJ_LIMIT); // RL10
      end
    end
    // channel bit high means switched on; hot channels held off
    chan_d       = latch_q & ~ovt_s2_q & {8{~off_q}}; // RL12 RL13
    fault_oe_n_d = ~fault_w; // RL11
  end
  always_ff @(posedge sys_clk or negedge dis_rst_n) begin
    if (!dis_rst_n) begin
      latch_q <= sosc_pkg::SOSC_BYTE_RST; // RL14
      chan_q  <= sosc_pkg::SOSC_BYTE_RST; // RL14
    end else begin
      latch_q <= latch_d;
      chan_q  <= chan_d;
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rej_q        <= sosc_pkg::SOSC_CNT_ZERO;
      off_q        <= 1'b0;
      fault_oe_n_q <= 1'b1;
    end else begin
      rej_q        <= rej_d;
      off_q        <= off_d;
      fault_oe_n_q <= fault_oe_n_d;
    end
  end
  assign channel_outputs   = chan_q;
  assign common_fault_o    = 1'b0;
  assign common_fault_oe_n = fault_oe_n_q;

  // ****************************************
  // apb registers and interrupt
  // ****************************************
  sosc_pkg::sosc_evt_s sts_q, sts_d, mask_q, mask_d, set_w;
  logic [31:0] rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic        setup_w, wr_w, hit_w;
  assign setup_w = psel & ~penable;
  assign wr_w    = psel & penable & pwrite;
  assign hit_w   = (paddr == sosc_pkg::SOSC_STS_OFS) | (paddr == sosc_pkg::SOSC_MASK_OFS) |
                   (paddr == sosc_pkg::SOSC_OUT_OFS) | (paddr == sosc_pkg::SOSC_FLT_OFS);
  always_comb begin
    set_w.accepted   = commit_w & valid_w;
    set_w.rejected   = commit_w & ~valid_w;
    set_w.fault      = fault_w;
    set_w.forced_off = off_d & ~off_q;
    sts_d   = sts_q;
    mask_d  = mask_q;
    rdata_d = rdata_q;
    if (wr_w && paddr == sosc_pkg::SOSC_STS_OFS) begin
      sts_d = sts_q & ~pwdata[3:0];
    end
    if (wr_w && paddr == sosc_pkg::SOSC_MASK_OFS) begin
      mask_d = pwdata[3:0];
    end
    // hardware set wins over a same-cycle clear
    sts_d = sts_d | set_w;
    if (setup_w) begin
      rdata_d = sosc_pkg::SOSC_WORD_RST;
      case (paddr)
        sosc_pkg::SOSC_STS_OFS:  rdata_d[3:0] = sts_q;
        sosc_pkg::SOSC_MASK_OFS: rdata_d[3:0] = mask_q;
        sosc_pkg::SOSC_OUT_OFS:  rdata_d[15:0] = {chan_q, latch_q};
        sosc_pkg::SOSC_FLT_OFS: begin
          rdata_d[7:0]                       = ovt_s2_q;
          rdata_d[sosc_pkg::SOSC_FLT_UV_POS]  = uv_s2_q;
          rdata_d[sosc_pkg::SOSC_FLT_PIN_POS] = pin_s2_q;
          rdata_d[sosc_pkg::SOSC_FLT_REJ_POS +: 3] = rej_q;
          rdata_d[sosc_pkg::SOSC_FLT_OFF_POS] = off_q;
        end
        default: rdata_d = sosc_pkg::SOSC_WORD_RST;
      endcase
    end
    irq_d = |(sts_q & mask_q);
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_q   <= sosc_pkg::SOSC_EVT_RST;
      mask_q  <= sosc_pkg::SOSC_EVT_RST;
      rdata_q <= sosc_pkg::SOSC_WORD_RST;
      irq_q   <= 1'b0;
    end else begin
      sts_q   <= sts_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end
  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_w;
  assign irq     = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_frame_start;
    (state_q == sosc_pkg::SOSC_IDLE) && !spi_s2_q.cs_n;
  endsequence
  sequence s_bad_commit;
    commit_w && !valid_w;
  endsequence
  property p_so_hiz;
    spi_s2_q.cs_n |=> so_oe_n;
  endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("serial output driven while deselected"); // RL3 RL5
  property p_so_start;
    s_frame_start |=> !so_oe_n && (so_o == $past(sreg_q[7]));
  endproperty
  a_so_start: assert property (p_so_start) else $error("serial output not driving top bit"); // RL1
  property p_shift_in;
    (state_q == sosc_pkg::SOSC_SHIFT) && !spi_s2_q.cs_n && rise_w
      |=> sreg_q == {$past(sreg_q[6:0]), $past(spi_s2_q.si)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted in"); // RL7 RL9
  property p_shift_out;
    (state_q == sosc_pkg::SOSC_SHIFT) && !spi_s2_q.cs_n && fall_w |=> so_o == $past(sreg_q[7]);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("serial output not advanced"); // RL8
  property p_commit_ok;
    commit_w && valid_w |=> latch_q == $past(sreg_q) ##1 chan_q == ($past(latch_q) & ~$past(ovt_s2_q));
  endproperty
  a_commit_ok: assert property (p_commit_ok) else $error("valid data not latched"); // RL2 RL13 RL15
  property p_commit_bad;
    s_bad_commit |=> $stable(latch_q);
  endproperty
  a_commit_bad: assert property (p_commit_bad) else $error("invalid transfer changed latches"); // RL6
  property p_four_rejects;
    s_bad_commit and (rej_q == 3'h3) |=> off_q ##1 chan_q == 8'h00;
  endproperty
  a_four_rejects: assert property (p_four_rejects) else $error("outputs not forced off"); // RL10
  property p_fault_pin;
    fault_w |=> !common_fault_oe_n;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled low"); // RL11
  property p_hot_off;
    |ovt_s2_q |=> (chan_q & $past(ovt_s2_q)) == 8'h00;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("hot channel left on"); // RL12
  property p_disable;
    !output_disable_n |-> channel_outputs == 8'h00 && latch_q == 8'h00;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not clear outputs"); // RL14
endmodule : sosc_top
`default_nettype wire

// [rtl/sosc_pkg.sv]
package sosc_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned SOSC_BITS      = 8;
  localparam int unsigned SOSC_EVT_W     = 4;
  localparam logic [2:0]  SOSC_CNT_ZERO  = 3'h0;
  localparam logic [2:0]  SOSC_REJ_LIMIT = 3'h4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] SOSC_STS_OFS  = 12'h000;
  localparam logic [11:0] SOSC_MASK_OFS = 12'h004;
  localparam logic [11:0] SOSC_OUT_OFS  = 12'h008;
  localparam logic [11:0] SOSC_FLT_OFS  = 12'h00c;

  // ****************************************
  // field positions in the fault register
  // ****************************************
  localparam int unsigned SOSC_FLT_UV_POS  = 8;
  localparam int unsigned SOSC_FLT_PIN_POS = 9;
  localparam int unsigned SOSC_FLT_REJ_POS = 10;
  localparam int unsigned SOSC_FLT_OFF_POS = 13;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0]  SOSC_EVT_RST  = 4'h0;
  localparam logic [7:0]  SOSC_BYTE_RST = 8'h00;
  localparam logic [31:0] SOSC_WORD_RST = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SOSC_IDLE   = 2'b00,
    SOSC_SHIFT  = 2'b01,
    SOSC_COMMIT = 2'b11
  } sosc_state_e;

  typedef struct packed {
    logic forced_off;
    logic fault;
    logic rejected;
    logic accepted;
  } sosc_evt_s;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } sosc_spi_s;

endpackage : sosc_pkg

// [testbench/sosc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sosc_host (
  // link pins
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  // serial return
  input  wire logic so_o,
  input  wire logic so_oe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    si   = 1'b0;
  end

  // ****************************************
  // one frame; sel low gives bus noise only
  // ****************************************
  task automatic frame(input logic sel, input int n, input logic [23:0] d,
                       output logic [23:0] rx, output logic oe);
    rx = 24'h0;
    oe = 1'b1;
    #2;
    cs_n = ~sel;
    #64;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      si   = d[i];
      #32;
      rx   = {rx[22:0], so_o};
      oe   = oe & (so_oe_n === 1'b0);
      sclk = 1'b1;
      #32;
    end
    cs_n = 1'b1;
    si   = ~si;
    #128;
  endtask : frame
endmodule : sosc_host
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              sys_clk = 1'b0;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              output_disable_n;
  logic              uv_flag;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [7:0]        ovt_flags;
  logic [7:0]        sreg_e = 8'h00;
  logic [7:0]        latch_e = 8'h00;
  logic [3:0]        sts_e = 4'h0;
  logic [3:0]        mask_e = 4'h0;
  logic [2:0]        rej_e = 3'h0;
  logic              off_e = 1'b0;
  wire logic [31:0]  prdata;
  wire logic [7:0]   channel_outputs;
  wire logic         pready, pslverr, cs_n, sclk, si, so_o, so_oe_n;
  wire logic         common_fault_o, common_fault_oe_n, irq;
  wire logic         common_fault_i;
  int                num_errors = 0;
  int                num_checks = 0;
  int                cycles = 0;

  // pull-up on the open-drain fault pin
  assign common_fault_i = common_fault_oe_n ? 1'b1 : common_fault_o;

  always #2.5 sys_clk = ~sys_clk;

  sosc_top i_dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                  .pslverr, .cs_n, .sclk, .si, .so_o, .so_oe_n, .output_disable_n, .ovt_flags,
                  .uv_flag, .channel_outputs, .common_fault_i, .common_fault_o, .common_fault_oe_n,
                  .irq);

  sosc_host i_host (.cs_n, .sclk, .si, .so_o, .so_oe_n);

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // ****************************************
  // apb master
  // ****************************************
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] e);
    logic [31:0] rd;
    logic        err;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, !(a[11:4] == 8'h00 && a[1:0] == 2'h0)}, {31'h0, err});
    if (!wr) chk("prdata", e, rd);
  endtask : bus

  // channel image from latch, hot channels and forced-off state
  function automatic logic [7:0] exp_chan(input logic [7:0] l, input logic [7:0] o, input logic f);
    return l & ~o & {8{~f}};
  endfunction : exp_chan

  task automatic regs();
    logic [7:0] ch;
    logic       flt;
    flt = |ovt_flags | uv_flag;
    if (flt) sts_e[2] = 1'b1;
    ch = exp_chan(latch_e, ovt_flags, off_e);
    chk("chan", {24'h0, ch}, {24'h0, channel_outputs});
    bus(1'b0, sosc_pkg::SOSC_OUT_OFS, 32'h0, {16'h0, ch, latch_e});
    bus(1'b0, sosc_pkg::SOSC_FLT_OFS, 32'h0, {18'h0, off_e, rej_e, ~flt, uv_flag, ovt_flags});
    bus(1'b0, sosc_pkg::SOSC_STS_OFS, 32'h0, {28'h0, sts_e});
    bus(1'b0, sosc_pkg::SOSC_MASK_OFS, 32'h0, {28'h0, mask_e});
    chk("irq", {31'h0, |(sts_e & mask_e)}, {31'h0, irq});
    chk("fault_oe_n", {31'h0, ~flt}, {31'h0, common_fault_oe_n});
  endtask : regs

  task automatic run(input logic sel, input int n, input logic [31:0] d);
    logic [23:0] rx;
    logic        oe;
    logic [31:0] c;
    d = d & ((32'h1 << n) - 32'h1);
    c = ({24'h0, sreg_e} << n) | d;
    i_host.frame(sel, n, d[23:0], rx, oe);
    if (sel) begin
      chk("so_bits", c >> 8, {8'h0, rx});
      chk("so_drive", 32'h1, {31'h0, oe});
      sreg_e = c[7:0];
      if (n % 8 == 0 && n > 0) begin
        latch_e = sreg_e;
        rej_e = 3'h0;
        off_e = 1'b0;
        sts_e[0] = 1'b1;
      end else begin
        sts_e[1] = 1'b1;
        if (rej_e < 3'h4) rej_e = rej_e + 3'h1;
        if (rej_e == 3'h4) off_e = 1'b1;
        if (off_e) sts_e[3] = 1'b1;
      end
    end
    chk("so_idle", 32'h1, {31'h0, so_oe_n});
    regs();
  endtask : run

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    output_disable_n = 1'b1;
    ovt_flags = 8'h00;
    uv_flag = 1'b0;
    void'($urandom(57280));
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    regs();
    bus(1'b1, 12'h010, 32'hffff_ffff, 32'h0);
    bus(1'b0, 12'h010, 32'h0, 32'h0);
    $display("reset and map test done");
    repeat (6) run(1'b1, 8 * $urandom_range(1, 3), $urandom());
    run(1'b1, 8, 32'h0000_00a5);
    $display("valid frame test done");
    run(1'b1, 7, $urandom());
    run(1'b1, 9, $urandom());
    run(1'b0, 8, $urandom());
    run(1'b1, 1, $urandom());
    run(1'b1, 0, $urandom());
    run(1'b1, 16, $urandom());
    $display("invalid frame test done");
    mask_e = 4'hf;
    bus(1'b1, sosc_pkg::SOSC_MASK_OFS, 32'hffff_ffff, 32'h0);
    regs();
    bus(1'b1, sosc_pkg::SOSC_STS_OFS, 32'h0000_000f, 32'h0);
    sts_e = 4'h0;
    regs();
    run(1'b1, 8, $urandom());
    $display("interrupt test done");
    ovt_flags <= 8'($urandom_range(1, 255));
    repeat (4) @(posedge sys_clk);
    regs();
    ovt_flags <= 8'h00;
    repeat (4) @(posedge sys_clk);
    regs();
    uv_flag <= 1'b1;
    repeat (4) @(posedge sys_clk);
    regs();
    uv_flag <= 1'b0;
    $display("fault test done");
    run(1'b1, 8, 32'h0000_00ff);
    @(posedge sys_clk);
    output_disable_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("chan_off", 32'h0, {24'h0, channel_outputs});
    @(posedge sys_clk);
    output_disable_n <= 1'b1;
    latch_e = 8'h00;
    sreg_e = 8'h00;
    repeat (4) @(posedge sys_clk);
    regs();
    run(1'b1, 8, $urandom());
    $display("disable test done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
